// ===== logic/tcu_regs.vh
`ifndef TCU_REGS_VH
`define TCU_REGS_VH
// Operation
// - Wide mode joins high and low timers.
// - Wide counter reloads zero after period match.
// - Wide mode uses only low clock select.
// - Clock is instruction cycle or pin fall.
// - Run bits gate wide, low-only or off.
// - Timer pin sampled twice per instruction cycle.
// - Period mode disables capture one entirely.
// - Timebase reloads zero after period match.
// - Edge field picks fall, rise, 4th, 16th.
// - Capture sets flag; interrupt needs three enables. Code uses two enables and a global disable bit that must be clear.
// - Capture flag cleared only by software.
// - Prescaler kept on change, reset by chip.
// - Capture works with pin as output port.
// - Capture pin synchronised before edge detection.
// - Event copies timebase unless value unread.
// - Event on unread value sets master overrun.
// - Both bytes read moves master to status.

`define TCU_CTRL 8'h00
`define TCU_IRQCTL 8'h04
`define TCU_LOWT 8'h08
`define TCU_HIGHT 8'h0c
`define TCU_PER_LO 8'h10
`define TCU_PER_HI 8'h14
`define TCU_TB_LO 8'h18
`define TCU_TB_HI 8'h1c
`define TCU_STATUS 8'h20
`define TCU_CLEAR 8'h24
`define TCU_ENABLE 8'h28
`define TCU_CH_BASE 8'h40
`define TCU_CAP_LO 4'h0
`define TCU_CAP_HI 4'h4
`define TCU_CAP_CFG 4'h8

`define TCU_C_WIDE 0
`define TCU_C_CLK1 1
`define TCU_C_CLK2 2
`define TCU_C_RUN1 3
`define TCU_C_RUN2 4
`define TCU_C_CAP1 5
`define TCU_C_TBRUN 6
`define TCU_I_PERIPH_IRQ_ENABLE 0
`define TCU_I_GDIS 1

`define TCU_CTRL_RST 8'h00
`define TCU_PER_RST 8'hff
`define TCU_CYC_LAST 2'h3
`endif

// ===== logic/tcu_top.v
`timescale 1ns/1ps
`include "tcu_regs.vh"
module tcu_top #(
  parameter NCH = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg irq_o,
  input wire ext_timer_clk_pin_i,
  input wire [NCH-1:0] capture_input_pin_i,
  output reg [NCH-1:0] capture_pin_o,
  output reg [NCH-1:0] capture_pin_oe_n_o
);
  localparam SW = NCH + 2;

  reg [7:0] ctrl_reg;
  reg [1:0] irqctl_reg;
  reg [7:0] low_timer_reg;
  reg [7:0] high_timer_reg;
  reg [7:0] low_timer_next;
  reg [7:0] high_timer_next;
  reg [7:0] per_lo_reg;
  reg [7:0] per_hi_reg;
  reg [15:0] tb_reg;
  reg [15:0] tb_next;
  reg [SW-1:0] status_reg;
  reg [SW-1:0] enable_reg;
  reg [2*NCH-1:0] edge_reg;
  reg [1:0] cyc_cnt_reg;
  reg ext_s1_reg;
  reg ext_s2_reg;
  reg ext_smp_reg;
  reg low_ev;
  reg high_ev;
  reg [31:0] rdata;
  integer i;

  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i & sel_i[0];
  wire rd = req & ~we_i;
  wire [7:0] wb = dat_i[7:0];
  wire [7:0] ch_off = adr_i - `TCU_CH_BASE;
  wire [1:0] ch_idx = ch_off[5:4];
  wire [3:0] ch_sub = ch_off[3:0];
  wire ch_hit = (adr_i >= `TCU_CH_BASE) && (ch_off[7:6] == 2'b00) && (ch_idx < NCH);

  wire wide = ctrl_reg[`TCU_C_WIDE];
  wire run1 = ctrl_reg[`TCU_C_RUN1];
  wire run2 = ctrl_reg[`TCU_C_RUN2];
  wire cap1_sel = ctrl_reg[`TCU_C_CAP1];

  // Instruction cycle is four clocks; the phase strobe fires twice in it.
  wire icyc = cyc_cnt_reg == `TCU_CYC_LAST;
  wire phase = cyc_cnt_reg[0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      cyc_cnt_reg <= 2'h0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_reg + 2'h1;
    end
  end

  // The first stage is read only by the second.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_smp_reg <= 1'b1;
    end else begin
      ext_s1_reg <= ext_timer_clk_pin_i;
      ext_s2_reg <= ext_s1_reg;
      if (phase) begin
        ext_smp_reg <= ext_s2_reg;
      end
    end
  end

  // Sampling adds up to a phase of delay from pin fall to the count.
  wire ext_fall = phase & ext_smp_reg & ~ext_s2_reg;
  wire tick1 = ctrl_reg[`TCU_C_CLK1] ? ext_fall : icyc;
  wire tick2 = ctrl_reg[`TCU_C_CLK2] ? ext_fall : icyc;
  wire [15:0] wide_cnt = {high_timer_reg, low_timer_reg};
  wire [15:0] wide_period_reg = {per_hi_reg, per_lo_reg};
  wire [15:0] wide_inc = wide_cnt + 16'h0001;

  always @* begin
    low_timer_next = low_timer_reg;
    high_timer_next = high_timer_reg;
    low_ev = 1'b0;
    high_ev = 1'b0;
    if (wide) begin
      if (run1 && tick1) begin
        if (run2) begin
          if (wide_cnt == wide_period_reg) begin
            low_timer_next = 8'h00;
            high_timer_next = 8'h00;
            low_ev = 1'b1;
          end else begin
            low_timer_next = wide_inc[7:0];
            high_timer_next = wide_inc[15:8];
          end
        end else begin
          low_timer_next = low_timer_reg + 8'h01;
        end
      end
    end else begin
      if (run1 && tick1) begin
        if (low_timer_reg == per_lo_reg) begin
          low_timer_next = 8'h00;
          low_ev = 1'b1;
        end else begin
          low_timer_next = low_timer_reg + 8'h01;
        end
      end
      if (run2 && tick2) begin
        if (high_timer_reg == per_hi_reg) begin
          high_timer_next = 8'h00;
          high_ev = 1'b1;
        end else begin
          high_timer_next = high_timer_reg + 8'h01;
        end
      end
    end
    // A software write wins over a count in the same cycle.
    if (wr && adr_i == `TCU_LOWT) begin
      low_timer_next = wb;
    end
    if (wr && adr_i == `TCU_HIGHT) begin
      high_timer_next = wb;
    end
  end

  wire [16*NCH-1:0] cap_all;
  wire [NCH-1:0] ovf_all;
  wire [NCH-1:0] cap_ev;

  always @* begin
    tb_next = tb_reg;
    if (ctrl_reg[`TCU_C_TBRUN] && icyc) begin
      if (!cap1_sel && tb_reg == cap_all[15:0]) begin
        tb_next = 16'h0000;
      end else begin
        tb_next = tb_reg + 16'h0001;
      end
    end
    if (wr && adr_i == `TCU_TB_LO) begin
      tb_next[7:0] = wb;
    end
    if (wr && adr_i == `TCU_TB_HI) begin
      tb_next[15:8] = wb;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `TCU_CTRL_RST;
      irqctl_reg <= 2'h0;
      low_timer_reg <= 8'h00;
      high_timer_reg <= 8'h00;
      per_lo_reg <= `TCU_PER_RST;
      per_hi_reg <= `TCU_PER_RST;
      tb_reg <= 16'h0000;
      enable_reg <= {SW{1'b0}};
      edge_reg <= {2*NCH{1'b0}};
      capture_pin_o <= {NCH{1'b0}};
      capture_pin_oe_n_o <= {NCH{1'b1}};
    end else begin
      low_timer_reg <= low_timer_next;
      high_timer_reg <= high_timer_next;
      tb_reg <= tb_next;
      if (wr) begin
        case (adr_i)
          `TCU_CTRL: ctrl_reg <= wb;
          `TCU_IRQCTL: irqctl_reg <= wb[1:0];
          `TCU_PER_LO: per_lo_reg <= wb;
          `TCU_PER_HI: per_hi_reg <= wb;
          `TCU_ENABLE: enable_reg <= wb[SW-1:0];
          default: begin
          end
        endcase
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (wr && ch_hit && ch_idx == i[1:0] && ch_sub == `TCU_CAP_CFG) begin
          edge_reg[2*i +: 2] <= wb[1:0];
          capture_pin_oe_n_o[i] <= ~wb[2];
          capture_pin_o[i] <= wb[3];
        end
      end
    end
  end

  // Hardware set beats a software clear landing in the same cycle.
  wire clr_hit = wr && adr_i == `TCU_CLEAR;
  wire [SW-1:0] clr_mask = clr_hit ? wb[SW-1:0] : {SW{1'b0}};
  wire [SW-1:0] events = {cap_ev, high_ev, low_ev};
  wire irq_ok = irqctl_reg[`TCU_I_PERIPH_IRQ_ENABLE] & ~irqctl_reg[`TCU_I_GDIS];

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= {SW{1'b0}};
      irq_o <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clr_mask) | events;
      irq_o <= (|(status_reg & enable_reg)) & irq_ok;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_cap
      localparam [1:0] CI = c;
      reg s1_reg;
      reg s2_reg;
      reg smp_reg;
      reg [3:0] presc_reg;
      reg [15:0] val_reg;
      reg full_reg;
      reg rd_lo_reg;
      reg rd_hi_reg;
      reg mst_ovf_reg;
      reg ovf_reg;
      reg hit_ev;
      wire me = ch_hit && ch_idx == CI;
      wire rd_lo = rd && me && ch_sub == `TCU_CAP_LO;
      wire rd_hi = rd && me && ch_sub == `TCU_CAP_HI;
      wire done = (rd_lo_reg | rd_lo) & (rd_hi_reg | rd_hi);
      wire dis = (c == 0) && !cap1_sel;
      wire src = capture_pin_oe_n_o[c] ? capture_input_pin_i[c] : capture_pin_o[c];
      wire rise = phase & ~smp_reg & s2_reg;
      wire fall = phase & smp_reg & ~s2_reg;
      wire [1:0] es = edge_reg[2*c +: 2];
      wire [3:0] presc_inc = presc_reg + 4'h1;

      always @* begin
        case (es)
          2'b00: hit_ev = fall;
          2'b01: hit_ev = rise;
          2'b10: hit_ev = rise && presc_reg[1:0] == 2'h3;
          2'b11: hit_ev = rise && presc_reg == 4'hf;
          default: hit_ev = 1'b0;
        endcase
      end

      wire ev = hit_ev & ~dis;
      assign cap_ev[c] = ev & ~full_reg;
      assign cap_all[16*c +: 16] = val_reg;
      assign ovf_all[c] = ovf_reg;

      always @(posedge clk_i) begin
        if (rst_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          smp_reg <= 1'b0;
          presc_reg <= 4'h0;
          val_reg <= 16'h0000;
          full_reg <= 1'b0;
          rd_lo_reg <= 1'b0;
          rd_hi_reg <= 1'b0;
          mst_ovf_reg <= 1'b0;
          ovf_reg <= 1'b0;
        end else begin
          s1_reg <= src;
          s2_reg <= s1_reg;
          if (phase) begin
            smp_reg <= s2_reg;
          end
          // The prescaler is never cleared by a mode change.
          if (rise) begin
            presc_reg <= presc_inc;
          end
          if (dis) begin
            if (wr && me && ch_sub == `TCU_CAP_LO) begin
              val_reg[7:0] <= wb;
            end
            if (wr && me && ch_sub == `TCU_CAP_HI) begin
              val_reg[15:8] <= wb;
            end
          end
          if (ev && !full_reg) begin
            val_reg <= tb_reg;
            full_reg <= 1'b1;
          end
          if (done && full_reg) begin
            full_reg <= 1'b0;
          end
          if (done) begin
            ovf_reg <= mst_ovf_reg;
            rd_lo_reg <= 1'b0;
            rd_hi_reg <= 1'b0;
          end else begin
            rd_lo_reg <= rd_lo_reg | rd_lo;
            rd_hi_reg <= rd_hi_reg | rd_hi;
          end
          // An overrun in the completing cycle stays pending for next time.
          mst_ovf_reg <= (ev & full_reg) | (mst_ovf_reg & ~done);
        end
      end
    end
  endgenerate

  always @* begin
    rdata = 32'h00000000;
    if (ch_hit) begin
      case (ch_sub)
        `TCU_CAP_LO: rdata[7:0] = cap_all[16*ch_idx +: 8];
        `TCU_CAP_HI: rdata[7:0] = cap_all[16*ch_idx + 8 +: 8];
        `TCU_CAP_CFG: begin
          rdata[1:0] = edge_reg[2*ch_idx +: 2];
          rdata[2] = ~capture_pin_oe_n_o[ch_idx];
          rdata[3] = capture_pin_o[ch_idx];
          rdata[4] = ovf_all[ch_idx];
        end
        default: rdata = 32'h00000000;
      endcase
    end else begin
      case (adr_i)
        `TCU_CTRL: rdata[7:0] = ctrl_reg;
        `TCU_IRQCTL: rdata[1:0] = irqctl_reg;
        `TCU_LOWT: rdata[7:0] = low_timer_reg;
        `TCU_HIGHT: rdata[7:0] = high_timer_reg;
        `TCU_PER_LO: rdata[7:0] = per_lo_reg;
        `TCU_PER_HI: rdata[7:0] = per_hi_reg;
        `TCU_TB_LO: rdata[7:0] = tb_reg[7:0];
        `TCU_TB_HI: rdata[7:0] = tb_reg[15:8];
        `TCU_STATUS: rdata[SW-1:0] = status_reg;
        `TCU_ENABLE: rdata[SW-1:0] = enable_reg;
        default: rdata = 32'h00000000;
      endcase
    end
  end

  // Unmapped addresses still answer, with zero data, so a master never hangs.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (rd) begin
        dat_o <= rdata;
      end
    end
  end
endmodule

// ===== testbench/tcu_top_sva.sv
`timescale 1ns/1ps
module tcu_top_sva #(
  parameter NCH = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire irq_o,
  input wire [NCH-1:0] capture_pin_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o;
  wire wr = req && we_i && sel_i[0];
  // Bus writes are shadowed so the interrupt gating can be judged from the ports alone.
  logic ok_reg;
  logic en_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ok_reg <= 1'b0;
      en_reg <= 1'b0;
    end else begin
      if (wr && adr_i == 8'h04) ok_reg <= dat_i[0] && !dat_i[1];
      if (wr && adr_i == 8'h28) en_reg <= |dat_i[NCH+1:0];
    end
  end
  AST_ACK_PULSE:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  AST_ACK_TAKE:
    assert property (req |=> ack_o) else $error("request not answered");
  AST_ACK_CAUSE:
    assert property (ack_o |-> $past(req)) else $error("ack without request");
  AST_DAT_HOLD:
    assert property (!ack_o |-> $stable(dat_o)) else $error("read data moved");
  AST_UNMAPPED:
    assert property (req && !we_i && adr_i == 8'h30 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_GATE:
    assert property (irq_o |-> $past(ok_reg)) else $error("irq while gated");
  AST_IRQ_MASK:
    assert property (irq_o |-> $past(en_reg)) else $error("irq while masked");
  AST_RST_OUT:
    assert property ($fell(rst_i) |-> !irq_o && &capture_pin_oe_n_o)
    else $error("outputs not reset");
endmodule

// ===== testbench/tcu_pins.sv
`timescale 1ns/1ps
module tcu_pins (
  input wire clk_i,
  output logic tclk_o,
  output logic [3:0] cap_o
);
  initial tclk_o = 1'b1;
  initial cap_o = 4'h0;
  // Levels last 8 clocks so both phase samples of an instruction cycle see them.
  task automatic tclk(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk_i);
      tclk_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      tclk_o <= 1'b1;
    end
  endtask
  task automatic lvl(input logic [3:0] m, input logic v);
    cap_o <= v ? (cap_o | m) : (cap_o & ~m);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [3:0] m);
    lvl(m, 1'b1);
    lvl(m, 1'b0);
  endtask
endmodule

// ===== testbench/tcu_top_test.sv
`timescale 1ns/1ps
module tcu_top_test;
  localparam NCH = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  wire [31:0] dat_o;
  wire ack_o;
  wire irq_o;
  wire tclk;
  wire [3:0] cap;
  wire [3:0] pin_o;
  wire [3:0] oe_n;
  logic [31:0] rd;
  logic [31:0] l1;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  tcu_top #(.NCH(NCH)) tcu_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_i, .sel_i, .dat_o, .ack_o, .irq_o, .ext_timer_clk_pin_i(tclk),
    .capture_input_pin_i(cap), .capture_pin_o(pin_o), .capture_pin_oe_n_o(oe_n));
  tcu_pins tcu_pins_inst (.clk_i, .tclk_o(tclk), .cap_o(cap));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    // The request stands until the rising edge at which ack is sampled high.
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic reset;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  initial begin
    reset();
    rchk(8'h00, 32'h0);
    rchk(8'h10, 32'hff);
    rchk(8'h14, 32'hff);
    rchk(8'h30, 32'h0);
    wr(8'h00, 32'h9);
    repeat (1200) @(posedge clk_i);
    wr(8'h00, 32'h1);
    rchk(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h19);
    repeat (1200) @(posedge clk_i);
    wr(8'h00, 32'h1);
    rchk(8'h0c, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h10);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h19);
    repeat (200) @(posedge clk_i);
    wr(8'h00, 32'h1);
    rchk(8'h20, 32'h1);
    rchk(8'h0c, 32'h0);
    wr(8'h24, 32'h1);
    rchk(8'h20, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'hff);
    wr(8'h14, 32'hff);
    wr(8'h00, 32'h1f);
    tcu_pins_inst.tclk(5);
    repeat (8) @(posedge clk_i);
    wr(8'h00, 32'h1);
    rchk(8'h08, 32'h5);
    // A second reset clears the prescalers, so the edge counts below start clean.
    reset();
    wr(8'h40, 32'hff);
    wr(8'h44, 32'hff);
    wr(8'h00, 32'h40);
    wr(8'h58, 32'h2);
    repeat (3) tcu_pins_inst.pulse(4'hf);
    rchk(8'h20, 32'h30);
    tcu_pins_inst.pulse(4'hf);
    rchk(8'h20, 32'h38);
    wr(8'h24, 32'hff);
    // Channels two and three are read out in full first, so their next captures load and set flags.
    bus(1'b0, 8'h60, 32'h0);
    bus(1'b0, 8'h64, 32'h0);
    bus(1'b0, 8'h70, 32'h0);
    bus(1'b0, 8'h74, 32'h0);
    wr(8'h78, 32'h1);
    tcu_pins_inst.lvl(4'hc, 1'b1);
    rchk(8'h20, 32'h20);
    tcu_pins_inst.lvl(4'hc, 1'b0);
    rchk(8'h20, 32'h30);
    bus(1'b0, 8'h50, 32'h0);
    l1 = rd;
    chk("capture loaded", 32'h1, {31'h0, l1 != 32'h0});
    repeat (4) tcu_pins_inst.pulse(4'h2);
    rchk(8'h58, 32'h2);
    rchk(8'h54, 32'h0);
    rchk(8'h50, l1);
    rchk(8'h58, 32'h12);
    wr(8'h28, 32'h10);
    wr(8'h04, 32'h1);
    @(negedge clk_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(8'h04, 32'h3);
    @(negedge clk_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(8'h24, 32'hff);
    bus(1'b0, 8'h60, 32'h0);
    bus(1'b0, 8'h64, 32'h0);
    wr(8'h68, 32'h5);
    chk("drive", 32'h0, {31'h0, oe_n[2]});
    wr(8'h68, 32'hd);
    repeat (8) @(posedge clk_i);
    chk("pin", 32'h1, {31'h0, pin_o[2]});
    rchk(8'h20, 32'h10);
    print_verdict();
  end
endmodule
bind tcu_top tcu_top_sva #(.NCH(NCH)) tcu_top_sva_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .irq_o, .capture_pin_oe_n_o);
